// [shared/ais_pkg.sv]
// shared constants for the amplifier command link, both ends
package ais_pkg;

    // 7-bit slave address; the strap supplies the least significant bit
    localparam logic [6:0] SLV_ADDR_BASE = 7'h40;
    // select code that turns the next byte into the read pointer
    localparam logic [7:0] RD_REQ_CODE   = 8'hd0;
    // direction bit following the slave address
    localparam logic       DIR_READ      = 1'b1;
    localparam logic       DIR_WRITE     = 1'b0;
    // bit position of the acknowledge slot within a byte frame
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    // value returned for a register that cannot be read
    localparam logic [7:0] UNREAD_VAL    = 8'hff;

    // timing: clock period and shortest low time of the bus clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_LOW_NS      = 1300;
    // a bit is four quarters, three with the clock low; two quarters must already cover the low time
    localparam int QTR_CYC = (T_LOW_NS / 2 + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;

endpackage

// [shared/ais_i2c_if.sv]
// open-drain two-wire bus joining the host end and the device end
`timescale 1ns/10ps
interface ais_i2c_if;

    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups: a line is low only where someone drives low
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport dev  (input scl, sda, output dev_sda_o, dev_sda_oe);
    modport host (input scl, sda,
                  output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);

endinterface

// [hdl/ais_dev.sv]
// device end: two-wire command slave giving access to control registers
`timescale 1ns/10ps

// Overview of operation
// R1: write registers, read all except unreadable ones
// R2: first byte: 7-bit address plus direction bit
// R3: answer address 40h or 41h by strap
// R4: receiver acks each byte but the last read byte and a foreign address byte, low means good
// R5: write: select address byte, then data byte
// R6: data bytes travel most significant bit first
// R7: read: request code, select, stop, then read
// R8: master acks each read byte but last
// R9: further write bytes go to next registers
module ais_dev
(
    // clock and reset
    input  wire logic       MCLK_I,
    input  wire logic       RST_I,
    // address strap
    input  wire logic       ADDR_SEL_I,
    // two-wire bus
    ais_i2c_if.dev          BUS,
    // register write side
    output logic            WR_STB_O,
    output logic [7:0]      WR_ADDR_O,
    output logic [7:0]      WR_DATA_O,
    // register read side
    output logic [7:0]      RD_ADDR_O,
    input  wire logic [7:0] RD_DATA_I,
    input  wire logic       RD_OK_I
);
    import ais_pkg::*;

    typedef enum logic [4:0]
    {
        D_IDLE = 5'b00001,
        D_RX   = 5'b00010,
        D_ACK  = 5'b00100,
        D_TX   = 5'b01000,
        D_MACK = 5'b10000
    } ais_dstate_t;

    ais_dstate_t state_q;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  bit_q;
    logic [1:0]  byte_n_q;
    logic        rw_q;
    logic        req_q;
    logic        mack_q;
    logic [7:0]  sh_q;
    logic [7:0]  tx_q;
    logic [7:0]  sel_q;
    logic [7:0]  rd_ptr_q;
    logic        sda_oe_q;
    logic        wr_stb_q;
    logic [7:0]  wr_addr_q;
    logic [7:0]  wr_data_q;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic [6:0]  my_addr;
    logic        byte_ok;
    logic        byte_end;
    logic        load_tx;
    logic [7:0]  ld_byte;

    // bus lines are taken as synchronous; one stage gives the edges
    assign scl_rise = BUS.scl & ~scl_q;
    assign scl_fall = ~BUS.scl & scl_q;
    assign start_c  = scl_q & BUS.scl & sda_q & ~BUS.sda;
    assign stop_c   = scl_q & BUS.scl & ~sda_q & BUS.sda;

    assign my_addr  = SLV_ADDR_BASE | {6'h00, ADDR_SEL_I};       // see R3
    // only the address byte can be refused; others are always taken
    assign byte_ok  = (byte_n_q != 2'd0) || (sh_q[7:1] == my_addr); // see R3
    assign byte_end = (state_q == D_RX) && scl_fall && (bit_q == ACK_SLOT);
    assign load_tx  = scl_fall && rw_q &&
                      ((state_q == D_ACK) || ((state_q == D_MACK) && mack_q));
    assign ld_byte  = RD_OK_I ? RD_DATA_I : UNREAD_VAL;          // see R1
    assign BUS.dev_sda_o  = 1'b0;
    assign BUS.dev_sda_oe = sda_oe_q;
    assign WR_STB_O       = wr_stb_q;
    assign WR_ADDR_O      = wr_addr_q;
    assign WR_DATA_O      = wr_data_q;
    assign RD_ADDR_O      = rd_ptr_q;

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= BUS.scl;
            sda_q <= BUS.sda;
        end
    end

    // byte framing; start and stop override any state
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_q  <= D_IDLE;
            bit_q    <= 4'h0;
            byte_n_q <= 2'd0;
            rw_q     <= DIR_WRITE;
            req_q    <= 1'b0;
            mack_q   <= 1'b0;
            sh_q     <= 8'h00;
        end
        else if (start_c)
        begin
            state_q  <= D_RX;
            bit_q    <= 4'h0;
            byte_n_q <= 2'd0;
            rw_q     <= DIR_WRITE;
        end
        else if (stop_c)
        begin
            state_q <= D_IDLE;
        end
        else
        begin
            case (state_q)
                D_RX:
                begin
                    if (scl_rise && (bit_q != ACK_SLOT))
                    begin
                        sh_q  <= {sh_q[6:0], BUS.sda};            // see R2
                        bit_q <= bit_q + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        if (!byte_ok)
                        begin
                            state_q <= D_IDLE;
                        end
                        else
                        begin
                            state_q <= D_ACK;
                            if (byte_n_q == 2'd0)
                            begin
                                rw_q  <= sh_q[0];                  // see R2
                                req_q <= 1'b0;
                            end
                            if ((byte_n_q == 2'd1) && (sh_q == RD_REQ_CODE))
                            begin
                                req_q <= 1'b1;                     // see R7
                            end
                            if (byte_n_q != 2'd2)
                            begin
                                byte_n_q <= byte_n_q + 2'd1;
                            end
                        end
                    end
                end
                D_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_q   <= 4'h0;
                        state_q <= (rw_q == DIR_READ) ? D_TX : D_RX;
                    end
                end
                D_TX:
                begin
                    if (scl_rise)
                    begin
                        bit_q <= bit_q + 4'h1;
                    end
                    else if (scl_fall && (bit_q == ACK_SLOT))
                    begin
                        state_q <= D_MACK;
                    end
                end
                D_MACK:
                begin
                    if (scl_rise)
                    begin
                        mack_q <= ~BUS.sda;                        // see R8
                    end
                    else if (scl_fall)
                    begin
                        // a missing ack ends the burst; wait for stop
                        bit_q   <= 4'h0;
                        state_q <= mack_q ? D_TX : D_IDLE;         // see R8
                    end
                end
                default:
                begin
                    state_q <= D_IDLE;
                end
            endcase
        end
    end

    // select address, read pointer and register write strobe
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sel_q     <= 8'h00;
            rd_ptr_q  <= 8'h00;
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end
        else
        begin
            wr_stb_q <= 1'b0;
            if (!start_c && !stop_c && byte_end && (rw_q == DIR_WRITE))
            begin
                if ((byte_n_q == 2'd1) && (sh_q != RD_REQ_CODE))
                begin
                    sel_q <= sh_q;                                 // see R5
                end
                else if ((byte_n_q == 2'd2) && req_q)
                begin
                    rd_ptr_q <= sh_q;                              // see R7
                end
                else if (byte_n_q == 2'd2)
                begin
                    wr_stb_q  <= 1'b1;                             // see R1
                    wr_addr_q <= sel_q;                            // see R5
                    wr_data_q <= sh_q;
                    sel_q     <= sel_q + 8'h01;                    // see R9
                end
            end
            else if (!start_c && !stop_c && load_tx)
            begin
                rd_ptr_q <= rd_ptr_q + 8'h01;                      // see R8
            end
        end
    end

    // transmit shifter and open-drain data drive
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            tx_q     <= 8'h00;
            sda_oe_q <= 1'b0;
        end
        else if (start_c || stop_c)
        begin
            sda_oe_q <= 1'b0;
        end
        else if (byte_end)
        begin
            sda_oe_q <= byte_ok;                                   // see R4
        end
        else if (load_tx)
        begin
            tx_q     <= ld_byte;
            sda_oe_q <= ~ld_byte[7];                               // see R6
        end
        else if (scl_fall && (state_q == D_TX))
        begin
            // after the eighth bit the line is left to the master's ack
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_q <= (bit_q == ACK_SLOT) ? 1'b0 : ~tx_q[6];     // see R6
        end
        else if (scl_fall && ((state_q == D_ACK) || (state_q == D_MACK)))
        begin
            sda_oe_q <= 1'b0;
        end
    end
endmodule

// [hdl/ais_host.sv]
// host end: two-wire bus master issuing register writes and reads
`timescale 1ns/10ps
module ais_host
#(
    parameter int LEN_W = 4
)
(
    // clock and reset
    input  wire logic             MCLK_I,
    input  wire logic             RST_I,
    // address strap of the addressed device
    input  wire logic             ADDR_SEL_I,
    // two-wire bus
    ais_i2c_if.host               BUS,
    // command
    input  wire logic             CMD_VALID_I,
    input  wire logic             CMD_READ_I,
    input  wire logic [7:0]       CMD_SEL_I,
    input  wire logic [LEN_W-1:0] CMD_LEN_I,
    output logic                  CMD_READY_O,
    // write data
    input  wire logic [7:0]       WDATA_I,
    output logic                  WTAKE_O,
    // read data
    output logic [7:0]            RDATA_O,
    output logic                  RVALID_O,
    // completion
    output logic                  DONE_O,
    output logic                  NACK_O
);
    import ais_pkg::*;

    localparam int IDX_W = LEN_W + 1;
    localparam int DIV_W = $clog2(QTR_CYC + 1);

    typedef enum logic [3:0]
    {
        H_IDLE  = 4'b0001,
        H_START = 4'b0010,
        H_BIT   = 4'b0100,
        H_STOP  = 4'b1000
    } ais_hstate_t;

    ais_hstate_t      state_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0]       ph_q;
    logic [3:0]       bit_q;
    logic [IDX_W-1:0] bidx_q;
    logic             seg_q;
    logic             rd_q;
    logic [7:0]       sel_q;
    logic [LEN_W-1:0] len_q;
    logic [6:0]       addr_q;
    logic [7:0]       sh_q;
    logic             nack_q;
    logic             scl_oe_q;
    logic             sda_oe_q;
    logic             ready_q;
    logic             wtake_q;
    logic [7:0]       rdata_q;
    logic             rvalid_q;
    logic             done_q;
    logic             nack_o_q;

    logic             tick;
    logic             rx_byte;
    logic             last;
    logic [IDX_W-1:0] nxt_idx;

    // byte sent at a given position of the current transaction
    function automatic logic [7:0] byte_at(input logic [IDX_W-1:0] idx);
        logic [7:0] b;
        b = UNREAD_VAL;
        if (idx == '0)
            b = {addr_q, seg_q};                                   // see R2
        else if (!seg_q && (idx == IDX_W'(1)))
            b = rd_q ? RD_REQ_CODE : sel_q;                        // see R7
        else if (!seg_q && (idx == IDX_W'(2)) && rd_q)
            b = sel_q;                                             // see R7
        else if (!seg_q)
            b = WDATA_I;                                           // see R5
        return b;
    endfunction

    assign tick    = (div_q == DIV_W'(QTR_CYC - 1));
    assign rx_byte = seg_q && (bidx_q != '0);
    assign nxt_idx = bidx_q + IDX_W'(1);
    assign last    = seg_q ? (bidx_q == {1'b0, len_q}) :
                     (rd_q ? (bidx_q == IDX_W'(2)) :
                      (bidx_q == ({1'b0, len_q} + IDX_W'(1))));

    assign BUS.host_scl_o  = 1'b0;
    assign BUS.host_sda_o  = 1'b0;
    assign BUS.host_scl_oe = scl_oe_q;
    assign BUS.host_sda_oe = sda_oe_q;
    assign CMD_READY_O     = ready_q;
    assign WTAKE_O         = wtake_q;
    assign RDATA_O         = rdata_q;
    assign RVALID_O        = rvalid_q;
    assign DONE_O          = done_q;
    assign NACK_O          = nack_o_q;

    // quarter-bit timebase, only running during a transaction
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
            div_q <= '0;
        else if ((state_q == H_IDLE) || tick)
            div_q <= '0;
        else
            div_q <= div_q + DIV_W'(1);
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_q  <= H_IDLE;
            ph_q     <= 2'd0;
            bit_q    <= 4'h0;
            bidx_q   <= '0;
            seg_q    <= DIR_WRITE;
            rd_q     <= 1'b0;
            sel_q    <= 8'h00;
            len_q    <= '0;
            addr_q   <= 7'h00;
            sh_q     <= 8'h00;
            nack_q   <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            ready_q  <= 1'b1;
            wtake_q  <= 1'b0;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            done_q   <= 1'b0;
            nack_o_q <= 1'b0;
        end
        else
        begin
            wtake_q  <= 1'b0;
            rvalid_q <= 1'b0;
            done_q   <= 1'b0;
            if (tick)
                ph_q <= ph_q + 2'd1;
            case (state_q)
                H_IDLE:
                begin
                    ph_q <= 2'd0;
                    if (CMD_VALID_I)
                    begin
                        state_q  <= H_START;
                        ready_q  <= 1'b0;
                        nack_o_q <= 1'b0;
                        nack_q   <= 1'b0;
                        seg_q    <= DIR_WRITE;
                        rd_q     <= CMD_READ_I;
                        sel_q    <= CMD_SEL_I;
                        len_q    <= CMD_LEN_I;
                        addr_q   <= SLV_ADDR_BASE | {6'h00, ADDR_SEL_I};
                    end
                end
                H_START:
                begin
                    // three released quarters give the bus free time
                    if (tick && (ph_q == 2'd2))
                        sda_oe_q <= 1'b1;
                    else if (tick && (ph_q == 2'd3))
                    begin
                        scl_oe_q <= 1'b1;
                        bidx_q   <= '0;
                        bit_q    <= 4'h0;
                        sh_q     <= byte_at('0);
                        state_q  <= H_BIT;
                    end
                end
                H_BIT:
                begin
                    if (tick && (ph_q == 2'd0))
                    begin
                        if (bit_q == ACK_SLOT)
                            sda_oe_q <= rx_byte && !last;          // see R8
                        else
                            sda_oe_q <= !rx_byte && !sh_q[7];      // see R6
                    end
                    else if (tick && (ph_q == 2'd2))
                        scl_oe_q <= 1'b0;
                    else if (tick && (ph_q == 2'd3))
                    begin
                        scl_oe_q <= 1'b1;
                        bit_q    <= bit_q + 4'h1;
                        if (bit_q != ACK_SLOT)
                            sh_q <= {sh_q[6:0], BUS.sda};          // see R6
                        else
                        begin
                            bit_q <= 4'h0;
                            if (rx_byte)
                            begin
                                rdata_q  <= sh_q;
                                rvalid_q <= 1'b1;
                            end
                            if (!rx_byte && BUS.sda)
                            begin
                                nack_q  <= 1'b1;                   // see R4
                                state_q <= H_STOP;
                            end
                            else if (last)
                                state_q <= H_STOP;
                            else
                            begin
                                bidx_q  <= nxt_idx;
                                sh_q    <= byte_at(nxt_idx);
                                wtake_q <= !seg_q && !rd_q &&
                                           (nxt_idx >= IDX_W'(2)); // see R9
                            end
                        end
                    end
                end
                H_STOP:
                begin
                    if (tick && (ph_q == 2'd0))
                        sda_oe_q <= 1'b1;
                    else if (tick && (ph_q == 2'd2))
                        scl_oe_q <= 1'b0;
                    else if (tick && (ph_q == 2'd3))
                    begin
                        sda_oe_q <= 1'b0;
                        if (!seg_q && rd_q && !nack_q)
                        begin
                            seg_q   <= DIR_READ;                   // see R7
                            state_q <= H_START;
                        end
                        else
                        begin
                            state_q  <= H_IDLE;
                            ready_q  <= 1'b1;
                            done_q   <= 1'b1;
                            nack_o_q <= nack_q;
                        end
                    end
                end
                default:
                    state_q <= H_IDLE;
            endcase
        end
    end

endmodule

// [bench/ais_link_properties.sv]
// link checker: wire timing of both ends and address handling of the device end
`timescale 1ns/10ps
module ais_link_properties
    import ais_pkg::*;
(
    // clock, reset and device strap
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic ADDR_SEL_I,
    // link signals
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic       first_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic       start_w;
    logic       rise_w;
    logic       match_w;

    assign start_w = scl_q & scl & sda_q & ~sda;
    assign rise_w  = scl & ~scl_q;
    assign match_w = shift_q[7:1] == {SLV_ADDR_BASE[6:1], ADDR_SEL_I};

    // edges seen one clock late, just as the device end sees them
    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            cnt_q   <= 4'h0;
            first_q <= 1'b0;
            shift_q <= 8'h00;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_w)
            begin
                cnt_q   <= 4'h0;
                first_q <= 1'b1;
            end
            else if (rise_w && cnt_q == ACK_SLOT)
            begin
                cnt_q   <= 4'h0;
                first_q <= 1'b0;
            end
            else if (rise_w)
            begin
                cnt_q   <= cnt_q + 4'h1;
                shift_q <= {shift_q[6:0], sda};
            end
        end
    end

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_ack_rise;
        rise_w && cnt_q == ACK_SLOT;
    endsequence

    property p_dev_od; !dev_sda_o; endproperty
    property p_host_od; !host_scl_o && !host_sda_o; endproperty
    property p_dev_change_low; $changed(dev_sda_oe) |-> !scl && !scl_q;
    endproperty
    property p_scl_high; $rose(scl) |=> scl [*8]; endproperty
    property p_scl_low; $fell(scl) |=> !scl [*8]; endproperty
    property p_addr_ack; s_ack_rise ##0 first_q |-> dev_sda_oe == match_w;
    endproperty
    property p_addr_quiet; first_q && cnt_q != ACK_SLOT |-> !dev_sda_oe;
    endproperty
    property p_nack_release; s_ack_rise ##0 sda |=> !dev_sda_oe [*8];
    endproperty

    a_dev_od: assert property (p_dev_od)
        else $error("device drives the data line high");
    a_host_od: assert property (p_host_od)
        else $error("host drives a line high");
    a_dev_change_low: assert property (p_dev_change_low)
        else $error("device data changed while clock high");
    a_scl_high: assert property (p_scl_high)
        else $error("clock high phase too short");
    a_scl_low: assert property (p_scl_low)
        else $error("clock low phase too short");
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("device drove during address byte");
    a_nack_release: assert property (p_nack_release)
        else $error("device kept driving after no acknowledge");
endmodule

// [bench/testbench.sv]
// self-checking bench: host end and device end on one link
`timescale 1ns/10ps
module testbench;
    import ais_pkg::*;

    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, dsel = 1'b0;
    logic        cvalid = 1'b0, cread = 1'b0;
    logic  [7:0] csel = 8'h00;
    logic  [3:0] clen = 4'h1;
    logic        cready, wtake, rvalid, done, nack, wstb, rd_ok, first_ack;
    logic  [7:0] wdata, rdata, waddr, wdat, raddr, rd_data, mbyte;
    logic  [7:0] regs [256];
    logic  [7:0] wbuf [8];
    logic [15:0] wr_q [$];
    logic  [7:0] rd_q [$];
    logic        scl_q = 1'b1, sda_q = 1'b1;
    int          widx = 0, mbit = 99, n_checks = 0, miscompares = 0;

    ais_i2c_if bus ();
    ais_host ais_host_inst (.MCLK_I(clk), .RST_I(rst), .ADDR_SEL_I(hsel),
        .BUS(bus.host), .CMD_VALID_I(cvalid), .CMD_READ_I(cread),
        .CMD_SEL_I(csel), .CMD_LEN_I(clen), .CMD_READY_O(cready),
        .WDATA_I(wdata), .WTAKE_O(wtake), .RDATA_O(rdata),
        .RVALID_O(rvalid), .DONE_O(done), .NACK_O(nack));
    ais_dev ais_dev_inst (.MCLK_I(clk), .RST_I(rst), .ADDR_SEL_I(dsel),
        .BUS(bus.dev), .WR_STB_O(wstb), .WR_ADDR_O(waddr),
        .WR_DATA_O(wdat), .RD_ADDR_O(raddr), .RD_DATA_I(rd_data),
        .RD_OK_I(rd_ok));
    ais_link_properties ais_link_properties_inst (.MCLK_I(clk),
        .RST_I(rst), .ADDR_SEL_I(dsel), .host_scl_o(bus.host_scl_o),
        .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
        .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
        .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));

    always #20 clk = ~clk;
    assign wdata   = wbuf[3'(widx)];
    assign rd_data = regs[raddr];
    // registers from f0h upward are unreadable in this bench
    assign rd_ok   = raddr < 8'hf0;

    // link monitor keeps the first byte after a start and its ack bit
    always @(negedge clk)
    begin
        if (bus.scl && scl_q && sda_q && !bus.sda)
            mbit = 0;
        if (bus.scl && !scl_q)
            mbit++;
        if (bus.scl && !scl_q && mbit <= 8)
            mbyte = {mbyte[6:0], bus.sda};
        if (bus.scl && !scl_q && mbit == 9)
            first_ack = bus.sda;
        scl_q = bus.scl;
        sda_q = bus.sda;
        if (wtake === 1'b1)
            widx++;
        if (wstb === 1'b1)
            wr_q.push_back({waddr, wdat});
        if (wstb === 1'b1)
            regs[waddr] = wdat;
        if (rvalid === 1'b1)
            rd_q.push_back(rdata);
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic run(input logic rd, input logic [7:0] sel,
                       input logic [3:0] len);
        int n;
        @(negedge clk);
        cread  = rd;
        csel   = sel;
        clen   = len;
        cvalid = 1'b1;
        @(negedge clk);
        cvalid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 20000)
            miscompares++;
    endtask

    task automatic t_write(input logic s);
        @(negedge clk);
        hsel = s;
        dsel = s;
        widx = 0;
        wr_q.delete();
        for (int i = 0; i < 8; i++)
            wbuf[i] = {s, 4'h3, 3'(i)};
        run(1'b0, 8'h10, 4'h3);
        check(mbyte, {SLV_ADDR_BASE[6:1], s, DIR_WRITE});
        check(first_ack, 1'b0);
        check(nack, 1'b0);
        check(16'(wr_q.size()), 16'h3);
        for (int i = 0; i < 3; i++)
            check(wr_q[i], {8'h10 + 8'(i), wbuf[i]});
    endtask

    task automatic t_read;
        @(negedge clk);
        hsel = 1'b0;
        dsel = 1'b0;
        rd_q.delete();
        run(1'b1, 8'h10, 4'h3);
        check(mbyte, {SLV_ADDR_BASE[6:1], 1'b0, DIR_READ});
        check(16'(rd_q.size()), 16'h3);
        for (int i = 0; i < 3; i++)
            check(rd_q[i], {1'b1, 4'h3, 3'(i)});
        rd_q.delete();
        run(1'b1, 8'hef, 4'h2);
        check(rd_q[0], 8'hef ^ 8'h5a);
        check(rd_q[1], UNREAD_VAL);
        check(nack, 1'b0);
    endtask

    task automatic t_mismatch;
        @(negedge clk);
        hsel = 1'b1;
        dsel = 1'b0;
        wr_q.delete();
        widx = 0;
        run(1'b0, 8'h20, 4'h1);
        check(nack, 1'b1);
        check(cready, 1'b1);
        check(first_ack, 1'b1);
        check(16'(wr_q.size()), 16'h0);
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        for (int i = 0; i < 256; i++)
            regs[i] = 8'(i) ^ 8'h5a;
        wbuf = '{default: 8'h00};
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_write(1'b0);
        t_write(1'b1);
        t_read();
        t_mismatch();
        end_of_test();
    end

    // hang guard, well beyond the roughly sixteen thousand cycles needed
    initial
    begin
        #3000000;
        miscompares++;
        end_of_test();
    end
endmodule
